// ==== hw/fsg_pkg.sv ====
// Constants and types of the flash self-programming guard.
// Assumes one 40 MHz clock and an asynchronous active-low reset.
//
// How it works
// - Stores executed from the application region are ignored entirely.
// - Boot-loader code may store to any flash address, lock modes permitting.
// - Region sizes follow the boot size fuses; read-while-write boundary is fixed.
// - Operations on read-while-write pages do not stall the core.
// - Operations on no-read-while-write pages stall the core until done.
// - Boot-loader region always lies inside the no-read-while-write region.
// - Busy flag rises with each page erase or write and stays one until software re-enable after it ends.
// - Lock bits can only be programmed; only chip erase or reset restores them.
// - General lock modes never gate self-programming stores or loads.
// - Application lock mode 1 imposes no restriction.
// - Application lock mode 2 blocks stores, permits loads.
// - Application lock mode 3 blocks stores and loads from boot code.
// - Application lock mode 4 blocks only loads from boot code.
// - Application modes 3, 4 with boot vectors suppress interrupts in application.
// - Boot lock mode 1 imposes no restriction.
// - Boot lock mode 2 blocks stores, permits loads.
// - Boot lock mode 3 blocks stores and loads from application code.
// - Boot lock mode 4 blocks only loads from application code.
// - Boot modes 3, 4 with application vectors suppress interrupts in boot.
package fsg_pkg;
    // ======================================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOCK = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam int CTRL_REEN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_STALL_BIT = 2;
    localparam int STAT_FUSE_LSB = 4;
    // ======================================================================
    // Lock bit positions; one means unprogrammed.
    localparam int LOCK_APP_LO = 0;
    localparam int LOCK_APP_UP = 1;
    localparam int LOCK_BOOT_LO = 2;
    localparam int LOCK_BOOT_UP = 3;
    localparam logic [3:0] LOCK_RESET = 4'hF;
    // ======================================================================
    // Store kinds
    localparam logic [1:0] KIND_BUF = 2'h0;
    localparam logic [1:0] KIND_ERASE = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;
    localparam logic [1:0] KIND_LOCK = 2'h3;
    // ======================================================================
    // Sizes in words; address and data widths in bits
    localparam int FLASH_AW = 15;
    localparam int BOOT_UNIT_WORDS = 512;
    localparam int NOREAD_WORDS = 4096;
    localparam int DATA_W = 16;
    localparam logic [15:0] BLOCKED_VALUE = 16'hFFFF;
    typedef enum logic [0:0] {
        FSG_IDLE = 1'b0,
        FSG_OP = 1'b1
    } fsg_phase_t;
endpackage : fsg_pkg

// ==== hw/fsg_guard.sv ====
// Flash self-programming guard: access checks, stall and busy flag.
// Assumes the core presents one store or load request per pulse on ref_clk,
// and the flash controller pulses op_done on ref_clk when an operation ends.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
module fsg_guard #(
    parameter int AW = fsg_pkg::FLASH_AW,
    parameter int DW = fsg_pkg::DATA_W,
    parameter int BOOT_UNIT = fsg_pkg::BOOT_UNIT_WORDS,
    parameter int NOREAD_SIZE = fsg_pkg::NOREAD_WORDS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fuses and external programming
    input wire logic [1:0] boot_region_size_fuses,
    input wire logic chip_erase,
    input wire logic ext_lock_valid,
    input wire logic [3:0] ext_lock_data,
    // Core side
    input wire logic [AW-1:0] exec_pc,
    input wire logic vectors_in_boot,
    input wire logic store_req,
    input wire logic [1:0] store_kind,
    input wire logic [AW-1:0] store_addr,
    input wire logic [3:0] store_lock_data,
    input wire logic load_req,
    input wire logic [AW-1:0] load_addr,
    input wire logic [DW-1:0] flash_rdata,
    output logic store_done,
    output logic store_blocked,
    output logic load_done,
    output logic load_blocked,
    output logic [DW-1:0] load_data,
    output logic cpu_stall,
    output logic irq_suppress,
    // Flash controller side
    output logic op_start,
    output logic [1:0] op_kind,
    output logic [AW-1:0] op_addr,
    input wire logic op_done
);
    localparam int FLASH_WORDS = 1 << AW;
    localparam logic [AW:0] NOREAD_START = (AW + 1)'(FLASH_WORDS - NOREAD_SIZE);

    // Refuse sizes that would let the largest boot region leave the halting region,
    // or a load word wider than the fixed value returned for a blocked load.
    if (BOOT_UNIT * 8 > NOREAD_SIZE || NOREAD_SIZE > FLASH_WORDS || DW > 16) begin : g_bad_size
        $error("fsg_guard: boot region cannot fit inside no-read-while-write region");
    end

    // ======================================================================
    // State
    typedef struct packed {
        logic [1:0] fuse_s1;
        logic [1:0] fuse_s2;
        logic [3:0] lock;
        fsg_pkg::fsg_phase_t phase;
        logic noread;
        logic busy;
        logic st_done;
        logic st_blk;
        logic ld_done;
        logic ld_blk;
        logic [DW-1:0] ld_data;
        logic irq_sup;
        logic start;
        logic [1:0] kind;
        logic [AW-1:0] addr;
        logic [31:0] rdata;
        logic err;
    } fsg_state_t;

    fsg_state_t state_reg;
    fsg_state_t state_next;

    // ======================================================================
    // Region classification
    logic [AW:0] boot_words;
    logic [AW:0] boot_start;
    logic pc_boot;
    logic st_boot;
    logic ld_boot;
    logic st_noread;
    logic st_allow;
    logic ld_allow;
    logic wr_acc;
    logic rd_setup;
    logic mapped;

    always_comb begin
        // Fuse value 3 selects the smallest region, 0 the largest.
        boot_words = (AW + 1)'(BOOT_UNIT) << (2'h3 - state_reg.fuse_s2);
        boot_start = (AW + 1)'(FLASH_WORDS) - boot_words;
        pc_boot = {1'b0, exec_pc} >= boot_start;
        st_boot = {1'b0, store_addr} >= boot_start;
        ld_boot = {1'b0, load_addr} >= boot_start;
        st_noread = {1'b0, store_addr} >= NOREAD_START;
        // Lower bit programmed blocks stores in modes 2 and 3.
        if (st_boot) begin
            st_allow = state_reg.lock[fsg_pkg::LOCK_BOOT_LO];
        end else begin
            st_allow = state_reg.lock[fsg_pkg::LOCK_APP_LO];
        end
        // Page buffer fills and lock writes touch no flash page.
        if (store_kind == fsg_pkg::KIND_BUF || store_kind == fsg_pkg::KIND_LOCK) begin
            st_allow = 1'b1;
        end
        // Only boot code may store, and never during an operation.
        st_allow = st_allow && pc_boot && state_reg.phase == fsg_pkg::FSG_IDLE;
        // Upper bit programmed blocks cross-region loads in modes 3 and 4.
        ld_allow = 1'b1;
        if (!ld_boot && pc_boot && !state_reg.lock[fsg_pkg::LOCK_APP_UP]) begin
            ld_allow = 1'b0;
        end
        if (ld_boot && !pc_boot && !state_reg.lock[fsg_pkg::LOCK_BOOT_UP]) begin
            ld_allow = 1'b0;
        end
        wr_acc = psel && penable && pwrite;
        rd_setup = psel && !penable;
        mapped = paddr == fsg_pkg::ADDR_CTRL || paddr == fsg_pkg::ADDR_LOCK || paddr == fsg_pkg::ADDR_STAT;
    end

    // ======================================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.fuse_s1 = boot_region_size_fuses;
        state_next.fuse_s2 = state_reg.fuse_s1;
        state_next.st_done = 1'b0;
        state_next.st_blk = 1'b0;
        state_next.ld_done = 1'b0;
        state_next.ld_blk = 1'b0;
        state_next.start = 1'b0;

        // Operation completion; the busy flag outlives it.
        if (state_reg.phase == fsg_pkg::FSG_OP && op_done) begin
            state_next.phase = fsg_pkg::FSG_IDLE;
            state_next.noread = 1'b0;
        end

        // Software re-enable clears busy only once the operation is over.
        if (wr_acc && paddr == fsg_pkg::ADDR_CTRL && pwdata[fsg_pkg::CTRL_REEN_BIT]
            && state_reg.phase == fsg_pkg::FSG_IDLE) begin
            state_next.busy = 1'b0;
        end

        // Lock bits: any writer may only program them.
        if (wr_acc && paddr == fsg_pkg::ADDR_LOCK) begin
            state_next.lock = state_next.lock & pwdata[3:0];
        end
        if (ext_lock_valid) begin
            state_next.lock = state_next.lock & ext_lock_data;
        end

        if (store_req) begin
            if (st_allow) begin
                state_next.st_done = 1'b1;
                if (store_kind == fsg_pkg::KIND_LOCK) begin
                    state_next.lock = state_next.lock & store_lock_data;
                end
                if (store_kind != fsg_pkg::KIND_LOCK) begin
                    state_next.start = 1'b1;
                    state_next.kind = store_kind;
                    state_next.addr = store_addr;
                end
                if (store_kind == fsg_pkg::KIND_ERASE || store_kind == fsg_pkg::KIND_WRITE) begin
                    state_next.phase = fsg_pkg::FSG_OP;
                    state_next.noread = st_noread;
                    // This set follows the re-enable above, so it wins when both fall in one cycle.
                    state_next.busy = 1'b1;
                end
            end else begin
                state_next.st_blk = 1'b1;
            end
        end

        if (chip_erase) begin
            state_next.lock = fsg_pkg::LOCK_RESET;
        end

        if (load_req) begin
            state_next.ld_done = 1'b1;
            state_next.ld_blk = !ld_allow;
            state_next.ld_data = ld_allow ? flash_rdata : fsg_pkg::BLOCKED_VALUE[DW-1:0];
        end

        state_next.irq_sup = (vectors_in_boot && !pc_boot && !state_reg.lock[fsg_pkg::LOCK_APP_UP])
            || (!vectors_in_boot && pc_boot && !state_reg.lock[fsg_pkg::LOCK_BOOT_UP]);

        // Read data is prepared in the setup phase and shown in the access phase.
        if (rd_setup) begin
            state_next.err = !mapped;
            state_next.rdata = 32'h0000_0000;
            case (paddr)
                fsg_pkg::ADDR_LOCK: begin
                    state_next.rdata[3:0] = state_reg.lock;
                end
                fsg_pkg::ADDR_STAT: begin
                    state_next.rdata[fsg_pkg::STAT_BUSY_BIT] = state_reg.busy;
                    state_next.rdata[fsg_pkg::STAT_ACTIVE_BIT] = state_reg.phase == fsg_pkg::FSG_OP;
                    state_next.rdata[fsg_pkg::STAT_STALL_BIT] = cpu_stall;
                    state_next.rdata[fsg_pkg::STAT_FUSE_LSB +: 2] = state_reg.fuse_s2;
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.fuse_s1 <= 2'h3;
            state_reg.fuse_s2 <= 2'h3;
            state_reg.lock <= fsg_pkg::LOCK_RESET;
            state_reg.phase <= fsg_pkg::FSG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // Outputs
    assign pready = 1'b1;
    assign pslverr = psel && penable && state_reg.err;
    assign prdata = state_reg.rdata;
    assign store_done = state_reg.st_done;
    assign store_blocked = state_reg.st_blk;
    assign load_done = state_reg.ld_done;
    assign load_blocked = state_reg.ld_blk;
    assign load_data = state_reg.ld_data;
    assign cpu_stall = state_reg.phase == fsg_pkg::FSG_OP && state_reg.noread;
    assign irq_suppress = state_reg.irq_sup;
    assign op_start = state_reg.start;
    assign op_kind = state_reg.kind;
    assign op_addr = state_reg.addr;

    // ======================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_app_store;
        store_req && !pc_boot;
    endsequence

    sequence s_page_op;
        store_req && st_allow && (store_kind == fsg_pkg::KIND_ERASE || store_kind == fsg_pkg::KIND_WRITE);
    endsequence

    chk_app_store_ignored: assert property (s_app_store |=> store_blocked && !op_start)
        else $error("store from application region was not ignored");
    chk_boot_store_ok: assert property (store_req && pc_boot && state_reg.phase == fsg_pkg::FSG_IDLE
        && store_kind == fsg_pkg::KIND_BUF |=> op_start && !store_blocked)
        else $error("buffer store from boot region was refused");
    chk_run_while_op: assert property ((s_page_op and !st_noread) |=> !cpu_stall && state_reg.busy)
        else $error("read-while-write operation stalled the core");
    chk_core_halted: assert property ((s_page_op and st_noread) |=> cpu_stall throughout
        (state_reg.phase == fsg_pkg::FSG_OP)[*1])
        else $error("no-read-while-write operation did not stall");
    chk_stall_ends: assert property (cpu_stall && op_done |=> !cpu_stall)
        else $error("stall outlived the operation");
    chk_boot_in_noread: assert property (boot_start >= NOREAD_START)
        else $error("boot region leaves the no-read-while-write region");
    chk_busy_holds: assert property (state_reg.busy && !(wr_acc && paddr == fsg_pkg::ADDR_CTRL)
        |=> state_reg.busy)
        else $error("busy flag dropped without re-enable");
    chk_busy_during_op: assert property (state_reg.phase == fsg_pkg::FSG_OP |-> state_reg.busy)
        else $error("busy flag low during an operation");
    chk_lock_only_prog: assert property (!chip_erase |=> (state_reg.lock & ~$past(state_reg.lock)) == 4'h0)
        else $error("lock bit returned to one without chip erase");
    chk_app_lock_store: assert property (store_req && pc_boot && !st_boot && store_kind == fsg_pkg::KIND_ERASE
        && !state_reg.lock[fsg_pkg::LOCK_APP_LO] |=> store_blocked ##1 !cpu_stall)
        else $error("store to locked application region was not blocked");
    chk_load_blocked: assert property (load_req && !ld_allow |=> load_blocked
        && load_data == fsg_pkg::BLOCKED_VALUE[DW-1:0])
        else $error("blocked load did not return the fixed value");
    chk_boot_lock_load: assert property (load_req && ld_boot && !pc_boot
        && !state_reg.lock[fsg_pkg::LOCK_BOOT_UP] |=> load_blocked)
        else $error("load of boot region from application was allowed");

    // ======================================================================
    // Lock mode and interrupt checks
    // A page erase or write issued by boot code while no operation runs.
    sequence s_boot_page_op;
        store_req && pc_boot && state_reg.phase == fsg_pkg::FSG_IDLE
            && (store_kind == fsg_pkg::KIND_ERASE || store_kind == fsg_pkg::KIND_WRITE);
    endsequence

    chk_app_store_open: assert property ((s_boot_page_op
        and (!st_boot && state_reg.lock[fsg_pkg::LOCK_APP_LO])) |=> store_done && op_start)
        else $error("store to an open application region was refused");
    chk_boot_store_lock: assert property ((s_boot_page_op
        and (st_boot && !state_reg.lock[fsg_pkg::LOCK_BOOT_LO])) |=> store_blocked && !op_start)
        else $error("store to a locked boot-loader region was not blocked");
    chk_boot_store_open: assert property ((s_boot_page_op
        and (st_boot && state_reg.lock[fsg_pkg::LOCK_BOOT_LO])) |=> store_done && op_start)
        else $error("store to an open boot-loader region was refused");
    chk_app_load_lock: assert property (load_req && pc_boot && !ld_boot
        && !state_reg.lock[fsg_pkg::LOCK_APP_UP] |=> load_blocked)
        else $error("load of application region from boot code was allowed");
    chk_open_load: assert property (load_req && state_reg.lock == fsg_pkg::LOCK_RESET
        |=> load_done && !load_blocked && load_data == $past(flash_rdata))
        else $error("load with all lock bits unprogrammed was refused");
    chk_irq_in_app: assert property (vectors_in_boot && !pc_boot
        && !state_reg.lock[fsg_pkg::LOCK_APP_UP] |=> irq_suppress)
        else $error("interrupts were not suppressed in application code");
    chk_irq_in_boot: assert property (!vectors_in_boot && pc_boot
        && !state_reg.lock[fsg_pkg::LOCK_BOOT_UP] |=> irq_suppress)
        else $error("interrupts were not suppressed in boot-loader code");
    chk_irq_free: assert property (state_reg.lock == fsg_pkg::LOCK_RESET |=> !irq_suppress)
        else $error("interrupts suppressed with all lock bits unprogrammed");
    chk_blocked_quiet: assert property (store_req && !st_allow
        && !(wr_acc && paddr == fsg_pkg::ADDR_CTRL) |=> !op_start && state_reg.busy == $past(state_reg.busy))
        else $error("blocked store started an operation or moved the busy flag");
    chk_busy_on_op: assert property (s_page_op |=> state_reg.busy && op_start)
        else $error("page operation did not raise the busy flag");
endmodule : fsg_guard

// ==== tb/fsg_flash_model.sv ====
// Behavioural flash controller facing the guard's command outputs.
// Assumes op_start is a one-cycle pulse on ref_clk; lat sets the operation length.
`timescale 1ns/10ps
module fsg_flash_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic op_start,
    input wire logic [7:0] lat,
    input wire logic load_req,
    input wire logic [14:0] load_addr,
    output logic [15:0] flash_rdata,
    output logic op_done
);
    logic [7:0] cnt;
    logic run;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            run <= 1'b0;
            op_done <= 1'b0;
        end else begin
            op_done <= 1'b0;
            if (op_start) begin
                run <= 1'b1;
                cnt <= lat;
            end else if (run && cnt == 8'h00) begin
                run <= 1'b0;
                op_done <= 1'b1;
            end else if (run) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
    // Read data is only meaningful in the cycle of a load; otherwise it is scrambled.
    assign flash_rdata = load_req ? {1'b1, load_addr} : ~{1'b1, load_addr};
endmodule : fsg_flash_model

// ==== tb/testbench.sv ====
// Self-checking bench of the flash self-programming guard.
// Assumes fsg_pkg, fsg_guard and fsg_flash_model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
    logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, chip_erase, ext_lock_valid, vectors_in_boot;
    logic store_req, load_req, store_done, store_blocked, load_done, load_blocked, cpu_stall, irq_suppress;
    logic op_start, op_done;
    logic [7:0] paddr, lat;
    logic [31:0] pwdata, prdata, v;
    logic [1:0] boot_region_size_fuses, store_kind, op_kind;
    logic [3:0] ext_lock_data, store_lock_data;
    logic [14:0] exec_pc, store_addr, load_addr, op_addr;
    logic [15:0] flash_rdata, load_data;
    logic [1:0] m_tab [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    int fail_count, n_checks;
    fsg_guard fsg_guard_i (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_region_size_fuses(boot_region_size_fuses), .chip_erase(chip_erase), .ext_lock_valid(ext_lock_valid),
        .ext_lock_data(ext_lock_data), .exec_pc(exec_pc), .vectors_in_boot(vectors_in_boot), .store_req(store_req),
        .store_kind(store_kind), .store_addr(store_addr), .store_lock_data(store_lock_data), .load_req(load_req),
        .load_addr(load_addr), .flash_rdata(flash_rdata), .store_done(store_done), .store_blocked(store_blocked),
        .load_done(load_done), .load_blocked(load_blocked), .load_data(load_data), .cpu_stall(cpu_stall),
        .irq_suppress(irq_suppress), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done));
    fsg_flash_model fsg_flash_model_i (.ref_clk(ref_clk), .resetn(resetn), .op_start(op_start), .lat(lat),
        .load_req(load_req), .load_addr(load_addr), .flash_rdata(flash_rdata), .op_done(op_done));
    // ======================================================================
    // Bus and core access tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); end while (pready !== 1'b1);
        rd = pslverr ? 32'hDEAD0000 | prdata : prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic do_store(input logic [14:0] pc, input logic [1:0] k, input logic [14:0] a, input logic ok);
        logic op;
        logic st;
        op = ok && (k == fsg_pkg::KIND_ERASE || k == fsg_pkg::KIND_WRITE);
        st = ok && k != fsg_pkg::KIND_LOCK;
        @(posedge ref_clk);
        exec_pc <= pc; store_req <= 1'b1; store_kind <= k; store_addr <= a;
        @(posedge ref_clk);
        store_req <= 1'b0;
        @(negedge ref_clk);
        `CHK("store_done", ok, store_done)
        `CHK("store_blocked", !ok, store_blocked)
        `CHK("op_start", st, op_start)
        if (st) `CHK("op_addr", a, op_addr)
        if (st) `CHK("op_kind", k, op_kind)
        `CHK("cpu_stall", op && a >= 15'h7000, cpu_stall)
    endtask : do_store
    task automatic finish_op(input logic st);
        while (op_done !== 1'b1) begin `CHK("stall_hold", st, cpu_stall) @(negedge ref_clk); end
        @(negedge ref_clk);
        `CHK("stall_end", 1'b0, cpu_stall)
        apb(0, fsg_pkg::ADDR_STAT, 0, v); `CHK("busy_held", 1'b1, v[0])
        apb(1, fsg_pkg::ADDR_CTRL, 32'h1, v);
        apb(0, fsg_pkg::ADDR_STAT, 0, v); `CHK("busy_clr", 1'b0, v[0])
    endtask : finish_op
    task automatic do_load(input logic [14:0] pc, input logic [14:0] a, input logic ok);
        @(posedge ref_clk);
        exec_pc <= pc; load_req <= 1'b1; load_addr <= a;
        @(posedge ref_clk);
        load_req <= 1'b0;
        @(negedge ref_clk);
        `CHK("load_done", 1'b1, load_done)
        `CHK("load_blocked", !ok, load_blocked)
        `CHK("load_data", ok ? {1'b1, a} : 16'hFFFF, load_data)
    endtask : do_load
    task automatic set_lock(input logic [3:0] lk);
        @(posedge ref_clk); chip_erase <= 1'b1;
        @(posedge ref_clk); chip_erase <= 1'b0;
        apb(1, fsg_pkg::ADDR_LOCK, {28'h0, lk}, v);
    endtask : set_lock
    task automatic chk_irq(input logic [14:0] pc, input logic vb, input logic e);
        @(posedge ref_clk); exec_pc <= pc; vectors_in_boot <= vb;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("irq_suppress", e, irq_suppress)
    endtask : chk_irq
    // ======================================================================
    // Scenarios
    task automatic t_reset;
        apb(0, fsg_pkg::ADDR_STAT, 0, v); `CHK("stat_rst", 32'h30, v)
        apb(0, fsg_pkg::ADDR_LOCK, 0, v); `CHK("lock_rst", 32'hF, v)
        apb(0, 8'h0C, 0, v); `CHK("unmapped", 32'hDEAD0000, v)
    endtask : t_reset
    task automatic t_app_ops;
        do_store(15'h0100, fsg_pkg::KIND_ERASE, 15'h0200, 0);
        apb(0, fsg_pkg::ADDR_STAT, 0, v); `CHK("busy_app", 32'h30, v)
        do_store(15'h7E00, fsg_pkg::KIND_BUF, 15'h0200, 1);
        lat <= 8'd40;
        do_store(15'h7E00, fsg_pkg::KIND_ERASE, 15'h0200, 1);
        do_load(15'h7E00, 15'h7100, 1);
        apb(0, fsg_pkg::ADDR_STAT, 0, v); `CHK("op_stat", 2'b11, v[1:0])
        do_store(15'h7E00, fsg_pkg::KIND_ERASE, 15'h0300, 0);
        finish_op(1'b0);
        lat <= 8'd3;
        do_store(15'h7E00, fsg_pkg::KIND_WRITE, 15'h7E10, 1);
        finish_op(1'b1);
    endtask : t_app_ops
    task automatic t_locks;
        logic [1:0] m;
        for (int i = 0; i < 8; i++) begin
            m = m_tab[i % 4];
            if (i < 4) begin
                set_lock({2'b11, m});
                do_store(15'h7E00, fsg_pkg::KIND_ERASE, 15'h0400, m[0]);
                if (m[0]) finish_op(1'b0);
                do_load(15'h7E00, 15'h0400, m[1]);
                chk_irq(15'h0100, 1'b1, !m[1]);
            end else begin
                set_lock({m, 2'b11});
                do_store(15'h7E00, fsg_pkg::KIND_ERASE, 15'h7E40, m[0]);
                if (m[0]) finish_op(1'b1);
                do_load(15'h0100, 15'h7E40, m[1]);
                chk_irq(15'h7E00, 1'b0, !m[1]);
            end
        end
    endtask : t_locks
    task automatic t_fuse_lock;
        @(posedge ref_clk);
        boot_region_size_fuses <= 2'b00;
        repeat (4) @(posedge ref_clk);
        apb(0, fsg_pkg::ADDR_STAT, 0, v); `CHK("fuse_sync", 2'b00, v[5:4])
        set_lock(4'hB);
        do_store(15'h7000, fsg_pkg::KIND_ERASE, 15'h7100, 0);
        @(posedge ref_clk);
        boot_region_size_fuses <= 2'b11;
        repeat (4) @(posedge ref_clk);
        do_store(15'h7E00, fsg_pkg::KIND_ERASE, 15'h7100, 1);
        finish_op(1'b1);
        set_lock(4'hF);
        @(posedge ref_clk); ext_lock_valid <= 1'b1; ext_lock_data <= 4'h7;
        @(posedge ref_clk); ext_lock_valid <= 1'b0;
        apb(1, fsg_pkg::ADDR_LOCK, 32'hF, v);
        apb(0, fsg_pkg::ADDR_LOCK, 0, v); `CHK("lock_ext", 32'h7, v)
        store_lock_data <= 4'h3;
        do_store(15'h7E00, fsg_pkg::KIND_LOCK, 15'h0000, 1);
        apb(0, fsg_pkg::ADDR_LOCK, 0, v); `CHK("lock_sw", 32'h3, v)
        set_lock(4'hF);
        apb(0, fsg_pkg::ADDR_LOCK, 0, v); `CHK("lock_ce", 32'hF, v)
    endtask : t_fuse_lock
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        boot_region_size_fuses = 2'b11; chip_erase = 1'b0; ext_lock_valid = 1'b0; ext_lock_data = 4'hF;
        exec_pc = 15'h0; vectors_in_boot = 1'b0; store_req = 1'b0; store_kind = 2'h0; store_addr = 15'h0;
        store_lock_data = 4'hF; load_req = 1'b0; load_addr = 15'h0; lat = 8'd3;
        fail_count = 0; n_checks = 0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_app_ops();
        t_locks();
        t_fuse_lock();
        end_sim();
    end
endmodule : testbench
